// ---- include/cbr_map.svh ----
// constants for the conversion result buffering block: register offsets, reset values, fields, timing
// assumes the includer only needs plain text macros; no logic lives here
`ifndef CBR_MAP_SVH
`define CBR_MAP_SVH

// structure defaults
`define CBR_WORD_BITS       24
`define CBR_NUM_CHAN        2

// register offsets (6-bit register address)
`define CBR_OFS_ID          6'h00
`define CBR_OFS_STATUS      6'h01
`define CBR_OFS_MODE        6'h02
`define CBR_OFS_CLOCK       6'h03
`define CBR_OFS_GAIN        6'h04
`define CBR_OFS_CFG         6'h06
`define CBR_OFS_CHAN0_PHASE_AND_INPUT_SELECT     6'h09
`define CBR_OFS_CH0_OCAL    6'h0a

// reset values
`define CBR_ID_UPPER        8'h22
`define CBR_RST_STATUS      16'h0540
`define CBR_RST_MODE        16'h0510
`define CBR_RST_CLOCK       16'h030e
`define CBR_RST_GAIN        16'h0000
`define CBR_RST_CFG         16'h0600
`define CBR_RST_CHAN0_PHASE_AND_INPUT_SELECT     16'h0000
`define CBR_RST_CH0_OCAL    16'h0000

// field positions
`define CBR_MODE_FMT_BIT    0
`define CBR_CLOCK_EN_LSB    8

// command word opcodes (top three bits of the 16-bit command)
`define CBR_OP_RREG         3'h5
`define CBR_OP_WREG         3'h3
`define CBR_OP_WREG_ACK     3'h2

// timing: core clock period and ready pulse width, in ns; cycles round up
`define CBR_CLK_PERIOD_NS   40
`define CBR_PULSE_NS        80
`define CBR_PULSE_CYC       ((`CBR_PULSE_NS + `CBR_CLK_PERIOD_NS - 1) / `CBR_CLK_PERIOD_NS)

`endif

// ---- include/cbr_pkg.sv ----
// types shared by the conversion result buffering block
// assumes nothing beyond a SystemVerilog compiler
package cbr_pkg;

   // ready pin generator states, one-hot
   typedef enum logic [3:0] {
      CBR_RDY_HIGH  = 4'b0001,
      CBR_RDY_BLIP  = 4'b0010,
      CBR_RDY_LOW   = 4'b0100,
      CBR_RDY_PULSE = 4'b1000
   } cbr_rdy_t;

endpackage

// ---- hw/cbr_chan_buf.sv ----
// one channel's output buffer and one-deep fifo stage
// assumes new_result, frame_read and clear are single-cycle pulses on clk
`include "cbr_map.svh"

module cbr_chan_buf #(
   parameter int WORD_BITS = `CBR_WORD_BITS
) (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // conversion side
   input  wire logic                 new_result,
   input  wire logic [WORD_BITS-1:0] result,
   // frame side
   input  wire logic                 frame_read,
   input  wire logic                 clear,
   output logic [WORD_BITS-1:0]      fifo_word,
   output logic                      unread,
   output logic                      pending,
   output logic                      fifo_loaded
);

   logic [WORD_BITS-1:0] out_ff;
   logic [WORD_BITS-1:0] fifo_ff;
   logic                 unread_ff;
   logic                 pending_ff;
   logic                 loaded_ff;

   // state as it stands once a completed frame is taken into account
   wire rd_copy   = frame_read & pending_ff;
   wire unread_r  = frame_read ? pending_ff : unread_ff;
   wire pending_r = frame_read ? 1'b0 : pending_ff;

   // a conversion loads both stages when the fifo is free or already one behind
   wire load_both = new_result & (~unread_r | pending_r);
   wire load_out  = new_result & unread_r & ~pending_r;

   wire [WORD_BITS-1:0] nxt_out     = clear ? '0 : (new_result ? result : out_ff);
   wire [WORD_BITS-1:0] nxt_fifo    = clear ? '0 : load_both ? result : rd_copy ? out_ff : fifo_ff;
   wire                 nxt_unread  = ~clear & (new_result | unread_r);
   wire                 nxt_pending = ~clear & (load_out | (pending_r & ~load_both));

   // single register per stage keeps exactly one result each
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_ff     <= '0;
         fifo_ff    <= '0;
         unread_ff  <= 1'b0;
         pending_ff <= 1'b0;
         loaded_ff  <= 1'b0;
      end else begin
         out_ff     <= nxt_out;
         fifo_ff    <= nxt_fifo;
         unread_ff  <= nxt_unread;
         pending_ff <= nxt_pending;
         loaded_ff  <= load_both & ~clear;
      end
   end

   assign fifo_word   = fifo_ff;
   assign unread      = unread_ff;
   assign pending     = pending_ff;
   assign fifo_loaded = loaded_ff;

   a_first_load: assert property (@(posedge clk) disable iff (!rst_n)
      (!unread_ff && !pending_ff && new_result && !frame_read && !clear)
      |=> (fifo_ff == $past(result)) && (out_ff == $past(result)) && loaded_ff)
      else $error("first result not placed in both stages");

   a_hold_older: assert property (@(posedge clk) disable iff (!rst_n)
      (unread_ff && !pending_ff && new_result && !frame_read && !clear)
      |=> (fifo_ff == $past(fifo_ff)) && (out_ff == $past(result)) && pending_ff)
      else $error("unread fifo result was replaced");

   a_copy_waiting: assert property (@(posedge clk) disable iff (!rst_n)
      (pending_ff && frame_read && !new_result && !clear)
      |=> (fifo_ff == out_ff) && unread_ff && !pending_ff)
      else $error("waiting result not copied after read");

   a_overwrite_both: assert property (@(posedge clk) disable iff (!rst_n)
      (pending_ff && new_result && !frame_read && !clear)
      |=> (fifo_ff == $past(result)) && (out_ff == fifo_ff) && !pending_ff)
      else $error("third result did not overwrite both stages");

   a_repeat_read: assert property (@(posedge clk) disable iff (!rst_n)
      (frame_read && !pending_ff && !new_result && !clear)
      |=> (fifo_ff == $past(fifo_ff)) && !unread_ff)
      else $error("fifo result changed or flag kept after plain read");

endmodule

// ---- hw/cbr_top.sv ----
// conversion result buffering, ready pin generation and the serial frame datapath
// assumes conversions arrive as clk-domain strobes; sclk, cs_n, din and the sync pin come from outside
`include "cbr_map.svh"

module cbr_top
   import cbr_pkg::*;
#(
   parameter int WORD_BITS = `CBR_WORD_BITS,
   parameter int NUM_CHAN  = `CBR_NUM_CHAN,
   parameter logic [7:0] ID_LOW = 8'h00      // arbitrary value for the low id byte
) (
   // core clock and reset
   input  wire logic                          clk,
   input  wire logic                          reset_n,
   // converter side
   input  wire logic                          conv_strobe,
   input  wire logic [NUM_CHAN*WORD_BITS-1:0] conv_data,
   output logic                               conv_resync,
   // sync pin and ready pin
   input  wire logic                          sync_reset_n,
   output logic                               conv_ready_pin_n,
   // serial link
   input  wire logic                          sclk,
   input  wire logic                          cs_n,
   input  wire logic                          din,
   output logic                               dout
);

   import cbr_pkg::*;

   localparam int FRAME_BITS = (NUM_CHAN + 1) * WORD_BITS;
   localparam int CNT_W      = $clog2(FRAME_BITS + 1);
   localparam logic [CNT_W-1:0] CNT_MAX   = CNT_W'(FRAME_BITS);
   localparam logic [CNT_W-1:0] CMD_LAST  = CNT_W'(WORD_BITS - 1);
   localparam logic [CNT_W-1:0] DATA_LAST = CNT_W'(2 * WORD_BITS - 1);
   localparam logic [CNT_W-1:0] LAST_BIT  = CNT_W'(FRAME_BITS - 1);
   localparam logic [3:0] PULSE_CYC = 4'(`CBR_PULSE_CYC);

   // elaboration checks: register map holds two channel enables and two flags
   if (NUM_CHAN != 2) begin : g_bad_chan
      $error("NUM_CHAN must be 2");
   end
   if (WORD_BITS < 16) begin : g_bad_word
      $error("WORD_BITS must be at least 16");
   end
   if (`CBR_PULSE_CYC < 1 || `CBR_PULSE_CYC > 15) begin : g_bad_pulse
      $error("pulse cycle count out of range");
   end

   // response word for a register write: opcode, address, count zero
   function automatic logic [15:0] wreg_ack(input logic [5:0] addr);
      wreg_ack = {`CBR_OP_WREG_ACK, addr, 7'h00};
   endfunction

   // reset release and pin synchronisers
   logic rst_meta_ff, rst_n_ff;
   logic cs_meta_ff, cs_sync_ff, cs_prev_ff;
   logic syn_meta_ff, syn_sync_ff, syn_prev_ff;
   logic done_meta_ff, done_sync_ff, done_prev_ff;
   logic done_tgl_ff;                                // flips in the link domain at each completed frame

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_ff <= 1'b0;
         rst_n_ff    <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n_ff    <= rst_meta_ff;
      end
   end

   // cs_n, the sync pin and the frame toggle pass two flops first; the command and data hold registers do not
   always_ff @(posedge clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         cs_meta_ff   <= 1'b1;
         cs_sync_ff   <= 1'b1;
         cs_prev_ff   <= 1'b1;
         syn_meta_ff  <= 1'b1;
         syn_sync_ff  <= 1'b1;
         syn_prev_ff  <= 1'b1;
         done_meta_ff <= 1'b0;
         done_sync_ff <= 1'b0;
         done_prev_ff <= 1'b0;
      end else begin
         cs_meta_ff   <= cs_n;
         cs_sync_ff   <= cs_meta_ff;
         cs_prev_ff   <= cs_sync_ff;
         syn_meta_ff  <= sync_reset_n;
         syn_sync_ff  <= syn_meta_ff;
         syn_prev_ff  <= syn_sync_ff;
         done_meta_ff <= done_tgl_ff;
         done_sync_ff <= done_meta_ff;
         done_prev_ff <= done_sync_ff;
      end
   end

   wire frame_start = cs_prev_ff & ~cs_sync_ff;
   wire sync_fall   = syn_prev_ff & ~syn_sync_ff;
   wire frame_done  = done_sync_ff ^ done_prev_ff;

   // link side: transmit on rising edges, receive on falling edges
   logic [CNT_W-1:0]          tx_cnt_ff;
   logic [CNT_W-1:0]          rx_cnt_ff;
   logic [WORD_BITS-1:0]      rx_sh_ff;
   logic [WORD_BITS-1:0]      cmd_hold_ff;
   logic [WORD_BITS-1:0]      data_hold_ff;
   logic                      dout_ff;
   logic [FRAME_BITS-1:0]     tx_frame_ff;

   // tx_frame_ff is loaded a few core cycles after cs_n falls and then held for the frame
   wire [FRAME_BITS-1:0] tx_shifted = tx_frame_ff << tx_cnt_ff;
   wire                  tx_bit     = tx_shifted[FRAME_BITS-1];
   wire [CNT_W-1:0]      nxt_tx_cnt = (tx_cnt_ff == CNT_MAX) ? tx_cnt_ff : tx_cnt_ff + CNT_W'(1);
   wire [CNT_W-1:0]      nxt_rx_cnt = (rx_cnt_ff == CNT_MAX) ? rx_cnt_ff : rx_cnt_ff + CNT_W'(1);
   wire [WORD_BITS-1:0]  rx_word    = {rx_sh_ff[WORD_BITS-2:0], din};

   // the frame's own select ends the bit counters, since sclk may stop between frames
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         tx_cnt_ff <= '0;
         dout_ff   <= 1'b0;
      end else begin
         tx_cnt_ff <= nxt_tx_cnt;
         dout_ff   <= tx_bit;
      end
   end

   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         rx_cnt_ff <= '0;
      end else begin
         rx_cnt_ff <= nxt_rx_cnt;
      end
   end

   // data path of the receiver carries no reset; it is qualified by the counter
   always_ff @(negedge sclk) begin
      rx_sh_ff <= rx_word;
      if (rx_cnt_ff == CMD_LAST) begin
         cmd_hold_ff <= rx_word;
      end
      if (rx_cnt_ff == DATA_LAST) begin
         data_hold_ff <= rx_word;
      end
   end

   // a short frame never toggles, so its data is not counted as read
   always_ff @(negedge sclk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         done_tgl_ff <= 1'b0;
      end else if (!cs_n && rx_cnt_ff == LAST_BIT) begin
         done_tgl_ff <= ~done_tgl_ff;
      end
   end

   // command fields; hold registers are stable for many core cycles after the frame ends
   wire [15:0] cmd_word = cmd_hold_ff[WORD_BITS-1 -: 16];
   wire [15:0] wr_word  = data_hold_ff[WORD_BITS-1 -: 16];
   wire [2:0]  cmd_op   = cmd_word[15:13];
   wire [5:0]  cmd_addr = cmd_word[12:7];
   wire        is_rreg  = frame_done & (cmd_op == `CBR_OP_RREG);
   wire        is_wreg  = frame_done & (cmd_op == `CBR_OP_WREG);

   // control registers
   logic [15:0] mode_ff, clock_ff, gain_ff, cfg_ff, ch0cfg_ff, ch0ocal_ff;
   logic [15:0] resp_ff;

   wire wr_mode    = is_wreg & (cmd_addr == `CBR_OFS_MODE);
   wire wr_clock   = is_wreg & (cmd_addr == `CBR_OFS_CLOCK);
   wire wr_gain    = is_wreg & (cmd_addr == `CBR_OFS_GAIN);
   wire wr_cfg     = is_wreg & (cmd_addr == `CBR_OFS_CFG);
   wire wr_ch0cfg  = is_wreg & (cmd_addr == `CBR_OFS_CHAN0_PHASE_AND_INPUT_SELECT);
   wire wr_ch0ocal = is_wreg & (cmd_addr == `CBR_OFS_CH0_OCAL);

   always_ff @(posedge clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         mode_ff    <= `CBR_RST_MODE;
         clock_ff   <= `CBR_RST_CLOCK;
         gain_ff    <= `CBR_RST_GAIN;
         cfg_ff     <= `CBR_RST_CFG;
         ch0cfg_ff  <= `CBR_RST_CHAN0_PHASE_AND_INPUT_SELECT;
         ch0ocal_ff <= `CBR_RST_CH0_OCAL;
      end else begin
         if (wr_mode)    mode_ff    <= wr_word;
         if (wr_clock)   clock_ff   <= wr_word;
         if (wr_gain)    gain_ff    <= wr_word;
         if (wr_cfg)     cfg_ff     <= wr_word;
         if (wr_ch0cfg)  ch0cfg_ff  <= wr_word;
         if (wr_ch0ocal) ch0ocal_ff <= wr_word;
      end
   end

   // channel buffers
   logic [NUM_CHAN*WORD_BITS-1:0] fifo_vec;
   logic [NUM_CHAN-1:0]           unread;
   logic [NUM_CHAN-1:0]           pending;
   logic [NUM_CHAN-1:0]           loaded;

   wire [NUM_CHAN-1:0] chan_en = clock_ff[`CBR_CLOCK_EN_LSB +: NUM_CHAN];

   for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
      cbr_chan_buf #(
         .WORD_BITS (WORD_BITS)
      ) u_buf (
         .clk         (clk),
         .rst_n       (rst_n_ff),
         .new_result  (conv_strobe & chan_en[i]),
         .result      (conv_data[i*WORD_BITS +: WORD_BITS]),
         .frame_read  (frame_done),
         .clear       (sync_fall),
         .fifo_word   (fifo_vec[i*WORD_BITS +: WORD_BITS]),
         .unread      (unread[i]),
         .pending     (pending[i]),
         .fifo_loaded (loaded[i])
      );
   end

   // status shows the per-channel new data flags in its low bits
   wire [15:0] status_word = `CBR_RST_STATUS | {14'h0000, unread};

   // register read selection; unmapped addresses read as zero
   wire [15:0] reg_rdata =
      (cmd_addr == `CBR_OFS_ID)       ? {`CBR_ID_UPPER, ID_LOW} :
      (cmd_addr == `CBR_OFS_STATUS)   ? status_word :
      (cmd_addr == `CBR_OFS_MODE)     ? mode_ff :
      (cmd_addr == `CBR_OFS_CLOCK)    ? clock_ff :
      (cmd_addr == `CBR_OFS_GAIN)     ? gain_ff :
      (cmd_addr == `CBR_OFS_CFG)      ? cfg_ff :
      (cmd_addr == `CBR_OFS_CHAN0_PHASE_AND_INPUT_SELECT)  ? ch0cfg_ff :
      (cmd_addr == `CBR_OFS_CH0_OCAL) ? ch0ocal_ff : 16'h0000;

   wire [15:0] nxt_resp = is_rreg ? reg_rdata : is_wreg ? wreg_ack(cmd_addr) : status_word;

   // the response is decided when a frame completes and goes out in the next one
   always_ff @(posedge clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         resp_ff     <= `CBR_RST_STATUS;
         tx_frame_ff <= '0;
      end else begin
         if (frame_done) begin
            resp_ff <= nxt_resp;
         end
         if (frame_start) begin
            tx_frame_ff <= {resp_ff, {(WORD_BITS-16){1'b0}}, fifo_vec};
         end
      end
   end

   // ready pin generator
   cbr_rdy_t   rdy_state_ff, nxt_rdy_state;
   logic [3:0] pulse_cnt_ff;
   logic       rdy_pin_ff;
   logic       resync_ff;

   wire fmt_pulse = mode_ff[`CBR_MODE_FMT_BIT];
   wire any_load  = |loaded;                // skipped when only the output buffer moved
   wire read_pend = frame_done & (|pending);

   always_comb begin
      nxt_rdy_state = rdy_state_ff;
      case (rdy_state_ff)
         CBR_RDY_BLIP:  nxt_rdy_state = CBR_RDY_LOW;
         CBR_RDY_PULSE: nxt_rdy_state = (pulse_cnt_ff == PULSE_CYC) ? CBR_RDY_HIGH : CBR_RDY_PULSE;
         default:       nxt_rdy_state = rdy_state_ff;
      endcase
      if (sync_fall) begin
         nxt_rdy_state = CBR_RDY_HIGH;
      end else if (any_load) begin
         nxt_rdy_state = fmt_pulse ? CBR_RDY_PULSE : CBR_RDY_BLIP;
      end else if (frame_done && !fmt_pulse) begin
         nxt_rdy_state = read_pend ? CBR_RDY_BLIP : CBR_RDY_HIGH;
      end
   end

   wire nxt_pin = ~((nxt_rdy_state == CBR_RDY_LOW) | (nxt_rdy_state == CBR_RDY_PULSE));

   always_ff @(posedge clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         rdy_state_ff <= CBR_RDY_HIGH;
         pulse_cnt_ff <= 4'h0;
         rdy_pin_ff   <= 1'b1;
         resync_ff    <= 1'b0;
      end else begin
         rdy_state_ff <= nxt_rdy_state;
         pulse_cnt_ff <= (rdy_state_ff == CBR_RDY_PULSE && nxt_rdy_state == CBR_RDY_PULSE) ?
                         pulse_cnt_ff + 4'h1 : 4'h1;
         rdy_pin_ff   <= nxt_pin;
         resync_ff    <= sync_fall;
      end
   end

   assign conv_ready_pin_n = rdy_pin_ff;
   assign conv_resync      = resync_ff;
   assign dout             = dout_ff;

   a_level_hold: assert property (@(posedge clk) disable iff (!rst_n_ff)
      (rdy_state_ff == CBR_RDY_LOW && !frame_done && !sync_fall && !any_load)
      |=> !rdy_pin_ff)
      else $error("ready released without a completed frame");

   a_pulse_width: assert property (@(posedge clk) disable iff (!rst_n_ff)
      (fmt_pulse && any_load && rdy_state_ff == CBR_RDY_HIGH && !sync_fall)
      |=> !rdy_pin_ff [*2] ##1 rdy_pin_ff)
      else $error("ready pulse width wrong");

   a_pulse_skip: assert property (@(posedge clk) disable iff (!rst_n_ff)
      (fmt_pulse && conv_strobe && (&unread) && !(|pending) && !frame_done && !sync_fall
       && rdy_state_ff == CBR_RDY_HIGH && !any_load)
      |-> ##2 rdy_pin_ff)
      else $error("ready pulse not skipped for unread fifo");

   a_sync_empty: assert property (@(posedge clk) disable iff (!rst_n_ff)
      sync_fall |=> (unread == '0) && (pending == '0) && resync_ff ##1 rdy_pin_ff)
      else $error("sync strobe did not empty buffers");

   a_frame_source: assert property (@(posedge clk) disable iff (!rst_n_ff)
      frame_start |=> tx_frame_ff[NUM_CHAN*WORD_BITS-1:0] == $past(fifo_vec))
      else $error("frame data not taken from fifo stage");

endmodule

// ---- verification/cbr_host.sv ----
// host side model: drives the four-wire link and captures what the device shifts out
// assumes the device samples din on the sclk fall and updates dout on the sclk rise
module cbr_host (
   // link
   output logic      sclk,
   output logic      cs_n,
   output logic      din,
   input  wire logic dout
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle link: sclk stands still between frames
   // the select rises at 1 ns on purpose: the select is the only reset of the link bit counters
   initial begin
      sclk = 1'b0;
      cs_n = 1'b0;
      din  = 1'b1;
      #1;
      cs_n = 1'b1;
   end

   // one frame of nbits clocks; 72 is a full read, fewer is an aborted frame
   task automatic xfer(input logic [15:0] cmd, input logic [15:0] wd, input int nbits,
                       output logic [71:0] rx);
      logic [71:0] tx;
      tx = {cmd, 8'h00, wd, 8'h00, 24'h000000};
      rx = '0;
      cs_n = 1'b0;
      #250;
      for (int k = 0; k < nbits; k++) begin
         sclk = 1'b1;
         din  = tx[71-k];
         #15;
         rx[71-k] = dout;
         sclk = 1'b0;
         #15;
      end
      cs_n = 1'b1;
      din  = ~din;  // released line shows the inverse, so a stale bit cannot pass
      #300;         // long idle gap so the completion crosses into the core domain
   endtask
endmodule

// ---- verification/tb.sv ----
// self-checking bench for the result buffering block, host model on the link
// assumes cbr_top with default parameters and the host model in cbr_host
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, reset_n, conv_strobe, conv_resync, sync_reset_n, rdy_n, sclk, cs_n, din, dout;
   logic [47:0] conv_data;
   logic [71:0] rx;
   int          n_mismatch, samples_checked, n_rise, n_fall;

   cbr_top DUT (.clk(clk), .reset_n(reset_n), .conv_strobe(conv_strobe), .conv_data(conv_data),
      .conv_resync(conv_resync), .sync_reset_n(sync_reset_n), .conv_ready_pin_n(rdy_n),
      .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
   cbr_host host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

   // core clock, 40 ns
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // edge counters on the ready pin; only differences are used, so the time-zero edge is harmless
   always @(posedge rdy_n) n_rise++;
   always @(negedge rdy_n) n_fall++;

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // one conversion; channel 1 carries d and goes out first of the two channels, after the response word; channel 0 its inverse
   task automatic strobe(input logic [23:0] d);
      @(negedge clk);
      conv_strobe = 1'b1;
      conv_data   = {d, ~d};
      @(negedge clk);
      conv_strobe = 1'b0;
      conv_data   = {~d, d};  // scrambled once no longer valid
      cyc(4);
   endtask
   task automatic rd();
      host.xfer(16'h0000, 16'h0000, 72, rx);
   endtask
   // register access: command frame, then the response frame
   task automatic reg_rd(input logic [5:0] a, output logic [15:0] v);
      host.xfer({3'b101, a, 7'h00}, 16'h0000, 72, rx);
      rd();
      v = rx[71:56];
   endtask
   task automatic reg_wr(input logic [5:0] a, input logic [15:0] d, output logic [15:0] ack);
      host.xfer({3'b011, a, 7'h00}, d, 72, rx);  // only mapped writable offsets are written
      rd();
      ack = rx[71:56];
   endtask

   task automatic t_regs();
      logic [5:0]  ofs [9] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h06, 6'h09, 6'h0a, 6'h05};
      logic [15:0] rv [9] = '{16'h2200, 16'h0540, 16'h0510, 16'h030e, 16'h0, 16'h0600, 16'h0, 16'h0, 16'h0};
      logic [15:0] v;
      // reset values of the map, offset 05 unmapped and reads zero
      foreach (ofs[i]) begin
         reg_rd(ofs[i], v);
         `CHK(v, rv[i])
      end
      $display("test regs done");
   endtask

   task automatic t_buffers();
      int r;
      strobe(24'h123456);
      `CHK(rdy_n, 1'b0)
      rd();
      `CHK(rx[47:0], {24'h123456, 24'hedcba9})
      `CHK(rdy_n, 1'b1)
      rd();
      `CHK(rx[47:24], 24'h123456)
      strobe(24'h00c0c0);
      strobe(24'h00d0d0);
      `CHK(rdy_n, 1'b0)
      r = n_rise;
      rd();  // two reads in quick succession
      `CHK(rx[47:24], 24'h00c0c0)
      `CHK(n_rise, r + 1)
      `CHK(rdy_n, 1'b0)
      rd();  // second set read at once, right after the blip
      `CHK(rx[47:24], 24'h00d0d0)
      `CHK(rdy_n, 1'b1)
      strobe(24'h0e0e0e);
      host.xfer(16'h0000, 16'h0000, 40, rx);
      strobe(24'h0f0f01);
      strobe(24'h0f0f02);
      rd();
      `CHK(rx[47:24], 24'h0f0f02)
      rd();
      `CHK(rx[71:56], 16'h0543)
      rd();
      `CHK(rx[71:56], 16'h0540)
      $display("test buffers done");
   endtask

   task automatic t_pulse();
      logic [15:0] v;
      int          r;
      reg_wr(6'h02, 16'h0511, v);
      `CHK(v, 16'h4100)
      r = n_fall;
      strobe(24'h0a0a0a);
      `CHK(n_fall, r + 1)
      `CHK(rdy_n, 1'b1)
      repeat (4) strobe(24'h0b0b0b);
      `CHK(n_fall, r + 3)
      reg_wr(6'h02, 16'h0510, v);
      $display("test pulse done");
   endtask

   task automatic t_sync();
      int seen;
      seen = 0;
      strobe(24'h0d0d0d);
      @(negedge clk);
      sync_reset_n = 1'b0;
      repeat (8) begin
         @(negedge clk);
         if (conv_resync === 1'b1) seen++;
      end
      sync_reset_n = 1'b1;
      cyc(4);
      `CHK(seen, 1)
      `CHK(rdy_n, 1'b1)
      strobe(24'h0c0c0c);
      rd();
      `CHK(rx[47:24], 24'h0c0c0c)
      $display("test sync done");
   endtask

   task automatic finish_test();
      $display("tb: %0d checks, %0d mismatches", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // main sequence: reset for five cycles, then the scenarios
   initial begin
      reset_n      = 1'b0;
      conv_strobe  = 1'b0;
      conv_data    = '0;
      sync_reset_n = 1'b1;
      cyc(5);
      reset_n = 1'b1;
      cyc(3);
      t_regs();
      t_buffers();
      t_pulse();
      t_sync();
      finish_test();
   end
   // watchdog: the run needs about 90 us, so 500 us means a hang
   initial begin
      #500000;
      n_mismatch++;
      $display("tb: watchdog expired");
      finish_test();
   end
endmodule
